// file: core/fpm_ctrl.sv
// Power-mode and page-size controller of a serial flash.
// Assumes SPI pins asynchronous to I_CLK_SYS and a busy input from the array.
`timescale 1ns/1ps
module fpm_ctrl #(
   parameter int N_RDPD_P  = fpm_pkg::N_RDPD,
   parameter int N_XUDPD_P = fpm_pkg::N_XUDPD,
   parameter int N_FP_P    = fpm_pkg::N_FP
) (
   // Clock and reset.
   input  wire logic I_CLK_SYS,
   input  wire logic I_RST,
   // SPI pins.
   input  wire logic I_CS_N,
   input  wire logic I_SCK,
   input  wire logic I_SI,
   // Array state.
   input  wire logic I_ARRAY_BUSY,
   // Status.
   output logic      O_READY,
   output logic      O_PAGE_256,
   output logic      O_DEEP_PD,
   output logic      O_ULTRA_PD,
   output logic      O_BUF_UNDEF,
   output logic      O_CMD_ENABLE
);
   initial begin
      if (N_RDPD_P < 1 || N_XUDPD_P < 1 || N_FP_P < 1 ||
          N_FP_P >= (1 << fpm_pkg::TMR_W)) begin
         $error("fpm_ctrl: timing counts out of range");
      end
   end

   typedef enum logic [6:0] {
      ST_STBY   = 7'h01,
      ST_TO_DPD = 7'h02,
      ST_DPD    = 7'h04,
      ST_RESUME = 7'h08,
      ST_TO_UPD = 7'h10,
      ST_UPD    = 7'h20,
      ST_XUPD   = 7'h40
   } fpm_state_t;

   typedef struct packed {
      fpm_state_t                 st;
      logic [fpm_pkg::TMR_W-1:0] tmr;
      logic [fpm_pkg::TMR_W-1:0] fp_tmr;
      logic                       cfg_busy;
      logic                       page_256;
      logic                       pend_256;
      logic                       buf_undef;
      logic [7:0]                 op;
      logic                       cfg_ok;
      logic                       cfg_sel;
      logic                       pulse_ok;
   } fpm_ctl_t;

   fpm_ctl_t    c_q, c_d;
   fpm_shift_if ev ();

   fpm_shifter u_shift (
      .i_clk  (I_CLK_SYS),
      .i_rst  (I_RST),
      .i_cs_n (I_CS_N),
      .i_sck  (I_SCK),
      .i_si   (I_SI),
      .ev     (ev.src)
   );

   function automatic logic [fpm_pkg::TMR_W-1:0] cnt(input int n);
      cnt = fpm_pkg::TMR_W'(n);
   endfunction : cnt

   // Expected configuration byte at a given position.
   function automatic logic cfg_match(input logic [2:0] idx,
                                      input logic [7:0] b);
      case (idx)
         3'h1:    cfg_match = (b == fpm_pkg::OP_CFG_B0);
         3'h2:    cfg_match = (b == fpm_pkg::OP_CFG_B1);
         3'h3:    cfg_match = (b == fpm_pkg::OP_CFG_B2);
         default: cfg_match = 1'b0;
      endcase
   endfunction : cfg_match

   logic busy_any;
   assign busy_any = c_q.cfg_busy | I_ARRAY_BUSY;

   always_comb begin
      c_d = c_q;
      if (ev.frame_start) begin
         c_d.op     = 8'h00;
         c_d.cfg_ok = 1'b1;
      end
      // Opcode is the first byte; later bytes never replace it.
      if (ev.byte_done) begin
         if (ev.byte_idx == 3'h1) begin
            c_d.op = ev.byte_val;
         end
         if (ev.byte_idx <= 3'h3) begin
            c_d.cfg_ok = c_q.cfg_ok & cfg_match(ev.byte_idx, ev.byte_val);
         end else if (ev.byte_idx == 3'h4) begin
            c_d.cfg_ok  = c_q.cfg_ok &
                          (ev.byte_val == fpm_pkg::OP_CFG_256 ||
                           ev.byte_val == fpm_pkg::OP_CFG_264);
            c_d.cfg_sel = (ev.byte_val == fpm_pkg::OP_CFG_256);
         end else begin
            c_d.cfg_ok = 1'b0;
         end
      end
      if (c_q.tmr != '0) begin
         c_d.tmr = c_q.tmr - cnt(1);
      end
      if (c_q.cfg_busy) begin
         if (c_q.fp_tmr == cnt(1)) begin
            c_d.cfg_busy = 1'b0;
            c_d.page_256 = c_q.pend_256;
         end
         c_d.fp_tmr = c_q.fp_tmr - cnt(1);
      end
      case (c_q.st)
         ST_STBY: begin
            if (ev.frame_end && ev.aligned && ev.byte_idx != 3'h0) begin
               if (c_q.op == fpm_pkg::OP_DEEP && !busy_any) begin
                  c_d.st  = ST_TO_DPD;
                  c_d.tmr = cnt(fpm_pkg::N_EDPD);
               end else if (c_q.op == fpm_pkg::OP_ULTRA &&
                            !busy_any) begin
                  c_d.st  = ST_TO_UPD;
                  c_d.tmr = cnt(fpm_pkg::N_EUDPD);
               end else if (c_d.cfg_ok && ev.byte_idx == 3'h4 &&
                            !busy_any) begin
                  c_d.cfg_busy = 1'b1;
                  c_d.pend_256 = c_q.cfg_sel;
                  c_d.fp_tmr   = cnt(N_FP_P);
               end
            end
            // Short or off-byte frames fall through and stay here.
         end
         ST_TO_DPD: begin
            if (c_q.tmr == '0) begin
               c_d.st = ST_DPD;
            end
         end
         ST_DPD: begin
            if (ev.frame_end && ev.aligned && ev.byte_idx != 3'h0 &&
                c_q.op == fpm_pkg::OP_RESUME) begin
               c_d.st  = ST_RESUME;
               c_d.tmr = cnt(N_RDPD_P);
            end
         end
         ST_RESUME: begin
            if (c_q.tmr == '0) begin
               c_d.st = ST_STBY;
            end
         end
         ST_TO_UPD: begin
            c_d.buf_undef = 1'b1;
            if (c_q.tmr == '0) begin
               c_d.st = ST_UPD;
            end
         end
         ST_UPD: begin
            if (ev.frame_start) begin
               c_d.pulse_ok = 1'b0;
            end
            if (ev.low_cycles >= 8'(fpm_pkg::N_CSLU)) begin
               c_d.pulse_ok = 1'b1;
            end
            if (ev.frame_end && c_d.pulse_ok) begin
               c_d.st  = ST_XUPD;
               c_d.tmr = cnt(N_XUDPD_P);
            end
         end
         ST_XUPD: begin
            if (c_q.tmr == '0) begin
               c_d.st = ST_STBY;
            end
         end
         default: begin
            c_d.st = ST_STBY;
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         c_q          <= '0;
         c_q.st       <= ST_STBY;
         c_q.page_256 <= fpm_pkg::PS_DELIVERED;
         c_q.pend_256 <= fpm_pkg::PS_DELIVERED;
      end else begin
         c_q <= c_d;
      end
   end

   always_comb begin
      O_READY      = ~busy_any;
      O_PAGE_256   = c_q.page_256;
      O_DEEP_PD    = (c_q.st == ST_DPD) || (c_q.st == ST_RESUME);
      O_ULTRA_PD   = (c_q.st == ST_UPD) || (c_q.st == ST_XUPD);
      O_BUF_UNDEF  = c_q.buf_undef;
      O_CMD_ENABLE = (c_q.st == ST_STBY);
   end
endmodule : fpm_ctrl

// file: core/fpm_pkg.sv
// Constants for the flash power-mode and page-size controller.
// Assumes a 20 MHz system clock; SPI pins are sampled, not used as clocks.
// Function
// - In deep power-down only the resume opcode is decoded.
// - Resume is opcode ABh; later bits in that selection are dropped.
// - Valid resume leaves deep power-down once the resume delay after deselect expires.
// - Short or off-byte resume is abandoned; device stays deep powered down.
// - Ultra-deep power-down entry marks both buffers as undefined.
// - In ultra-deep power-down every opcode is ignored.
// - Opcode 79h then deselect enters ultra-deep power-down after delay.
// - Short or off-byte ultra-deep request is cancelled; stays standby.
// - Reset always starts the device in standby.
// - Ultra-deep request is dropped while a self-timed cycle runs.
// - A chip-select pulse of minimum width leaves ultra-deep power-down.
// - Selections before exit delay expires are discarded.
// - Page size is 256 or 264 bytes, either direction allowed.
// - Page size is held in a nonvolatile register; here reset reloads the delivered 264-byte setting.
// - Delivered setting is 264-byte pages.
// - Sequence 3Dh 2Ah 80h A6h then deselect programs 256-byte size.
// - Sequence 3Dh 2Ah 80h A7h then deselect programs 264-byte size.
// - Busy is reported throughout the configuration program time.
// - New page size takes effect as soon as the cycle ends.
// - Ready flag is 0 during a self-timed operation, 1 when ready.
// - Page-size flag reports 256-byte or 264-byte configuration.
// - Opcode B9h then byte-aligned deselect enters deep power-down.
package fpm_pkg;
   localparam logic [7:0] OP_RESUME   = 8'hAB;
   localparam logic [7:0] OP_DEEP     = 8'hB9;
   localparam logic [7:0] OP_ULTRA    = 8'h79;
   localparam logic [7:0] OP_CFG_B0   = 8'h3D;
   localparam logic [7:0] OP_CFG_B1   = 8'h2A;
   localparam logic [7:0] OP_CFG_B2   = 8'h80;
   localparam logic [7:0] OP_CFG_256  = 8'hA6;
   localparam logic [7:0] OP_CFG_264  = 8'hA7;
   localparam int         CLK_MHZ     = 20;
   // Timings in ns.
   localparam int         T_RDPD_NS   = 35000;
   localparam int         T_EDPD_NS   = 3000;
   localparam int         T_EUDPD_NS  = 3000;
   localparam int         T_XUDPD_NS  = 70000;
   localparam int         T_CSLU_NS   = 20;
   localparam int         T_FP_NS     = 200000;
   localparam int         N_RDPD  = T_RDPD_NS * CLK_MHZ / 1000;
   localparam int         N_EDPD  = T_EDPD_NS * CLK_MHZ / 1000;
   localparam int         N_EUDPD = T_EUDPD_NS * CLK_MHZ / 1000;
   localparam int         N_CSLU_R = (T_CSLU_NS * CLK_MHZ + 999) / 1000;
   localparam int         N_CSLU  = (N_CSLU_R < 1) ? 1 : N_CSLU_R;
   localparam int         N_XUDPD = T_XUDPD_NS * CLK_MHZ / 1000;
   localparam int         N_FP    = T_FP_NS * CLK_MHZ / 1000;
   localparam logic       PS_264      = 1'b0;
   localparam logic       PS_256      = 1'b1;
   localparam logic       PS_DELIVERED = PS_264;
   localparam int         TMR_W       = 24;
endpackage : fpm_pkg

// file: core/fpm_shift_if.sv
// Carries decoded serial-frame events from the shifter to the controller.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface fpm_shift_if;
   logic       frame_start;
   logic       frame_end;
   logic       byte_done;
   logic [7:0] byte_val;
   logic [2:0] byte_idx;
   logic       aligned;
   logic [7:0] low_cycles;
   modport src (output frame_start, frame_end, byte_done, byte_val,
                output byte_idx, aligned, low_cycles);
   modport dst (input frame_start, frame_end, byte_done, byte_val,
                input byte_idx, aligned, low_cycles);
endinterface : fpm_shift_if

// file: core/fpm_shifter.sv
// Synchronises SPI pins and assembles bytes from sampled rising edges.
// Assumes SCK is much slower than the 20 MHz system clock.
`timescale 1ns/1ps
module fpm_shifter (
   // Clock and reset.
   input  wire logic  i_clk,
   input  wire logic  i_rst,
   // Pins.
   input  wire logic  i_cs_n,
   input  wire logic  i_sck,
   input  wire logic  i_si,
   // Events.
   fpm_shift_if.src   ev
);
   typedef struct packed {
      logic [2:0] cs_s;
      logic [2:0] sck_s;
      logic [2:0] si_s;
      logic       cs_n;
      logic       sck;
      logic [2:0] bitc;
      logic [7:0] sr;
      logic [2:0] idx;
      logic [7:0] low;
      logic       fs;
      logic       fe;
      logic       bd;
      logic [7:0] bv;
   } fpm_shf_t;
   fpm_shf_t s_q, s_d;

   always_comb begin
      s_d       = s_q;
      s_d.cs_s  = {s_q.cs_s[1:0], i_cs_n};
      s_d.sck_s = {s_q.sck_s[1:0], i_sck};
      s_d.si_s  = {s_q.si_s[1:0], i_si};
      s_d.fs    = 1'b0;
      s_d.fe    = 1'b0;
      s_d.bd    = 1'b0;
      if (s_q.cs_s[2] == s_q.cs_s[1]) begin
         s_d.cs_n = s_q.cs_s[2];
      end
      if (s_q.sck_s[2] == s_q.sck_s[1]) begin
         s_d.sck = s_q.sck_s[2];
      end
      if (s_q.cs_n && !s_d.cs_n) begin
         s_d.fs   = 1'b1;
         s_d.bitc = 3'h0;
         s_d.idx  = 3'h0;
         s_d.low  = 8'h00;
      end else if (!s_q.cs_n && s_d.cs_n) begin
         s_d.fe = 1'b1;
      end
      if (!s_q.cs_n && s_q.low != 8'hFF) begin
         s_d.low = s_q.low + 8'h01;
      end
      if (!s_q.cs_n && !s_q.sck && s_d.sck) begin
         s_d.sr   = {s_q.sr[6:0], s_q.si_s[2]};
         s_d.bitc = s_q.bitc + 3'h1;
         if (s_q.bitc == 3'h7) begin
            s_d.bd = 1'b1;
            s_d.bv = {s_q.sr[6:0], s_q.si_s[2]};
            if (s_q.idx != 3'h7) begin
               s_d.idx = s_q.idx + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '{cs_s: 3'h7, cs_n: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign ev.frame_start = s_q.fs;
   assign ev.frame_end   = s_q.fe;
   assign ev.byte_done   = s_q.bd;
   assign ev.byte_val    = s_q.bv;
   assign ev.byte_idx    = s_q.idx;
   assign ev.aligned     = (s_q.bitc == 3'h0);
   assign ev.low_cycles  = s_q.low;
endmodule : fpm_shifter

// file: test/flash_power_mode_and_page_size_control_test.sv
// Self-checking bench of the power-mode and page-size controller.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
module flash_power_mode_and_page_size_control_test;
   logic clk, rst, busy, cs_n, sck, si;
   logic rdy, p256, dpd, upd, bufu, cmd;
   int   n_mismatch = 0;
   int   n_tests    = 0;
   initial clk = 1'b0;
   always #25 clk = ~clk;
   fpm_host_model u_host (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck),
      .o_si(si));
   fpm_ctrl #(.N_RDPD_P(20), .N_XUDPD_P(200), .N_FP_P(40)) u_dut (
      .I_CLK_SYS(clk), .I_RST(rst), .I_CS_N(cs_n), .I_SCK(sck),
      .I_SI(si), .I_ARRAY_BUSY(busy), .O_READY(rdy), .O_PAGE_256(p256),
      .O_DEEP_PD(dpd), .O_ULTRA_PD(upd), .O_BUF_UNDEF(bufu),
      .O_CMD_ENABLE(cmd));
   task automatic chk(input logic ok, input string msg);
      // Waits past the launching edge so registered outputs have settled.
      #1;
      n_tests++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic t_reset();
      chk(cmd === 1'b1 && dpd === 1'b0 && upd === 1'b0, "not standby");
      chk(p256 === 1'b0 && rdy === 1'b1, "not 264 ready");
      $display("test reset done");
   endtask : t_reset
   task automatic t_deep();
      u_host.send(32'hB900_0000, 8);
      repeat (100) if (dpd !== 1'b1) @(posedge clk);
      chk(dpd === 1'b1 && cmd === 1'b0, "no deep entry");
      u_host.send(32'hB900_0000, 8);
      u_host.send(32'hD700_0000, 8);
      repeat (100) @(posedge clk);
      chk(dpd === 1'b1, "opcode decoded in deep");
      u_host.send(32'hAB00_0000, 5);
      u_host.send(32'hABC0_0000, 10);
      repeat (100) @(posedge clk);
      chk(dpd === 1'b1, "partial resume obeyed");
      u_host.send(32'hAB5A_0000, 16);
      repeat (60) if (cmd !== 1'b1) @(posedge clk);
      chk(dpd === 1'b0 && cmd === 1'b1, "no resume");
      $display("test deep done");
   endtask : t_deep
   task automatic t_ultra();
      u_host.send(32'h7980_0000, 12);
      repeat (100) @(posedge clk);
      chk(upd === 1'b0 && cmd === 1'b1, "off-byte entry");
      #1 busy = 1'b1;
      u_host.send(32'h7900_0000, 8);
      repeat (100) @(posedge clk);
      chk(upd === 1'b0 && rdy === 1'b0, "entry while busy");
      @(posedge clk);
      #1 busy = 1'b0;
      u_host.send(32'h79FF_0000, 16);
      repeat (100) if (upd !== 1'b1) @(posedge clk);
      chk(upd === 1'b1 && bufu === 1'b1, "no ultra entry");
      u_host.send(32'hAB00_0000, 8);
      chk(dpd === 1'b0, "resume taken in ultra");
      u_host.send(32'hB900_0000, 8);
      repeat (300) if (cmd !== 1'b1) @(posedge clk);
      repeat (100) @(posedge clk);
      chk(cmd === 1'b1 && dpd === 1'b0, "early frame obeyed");
      $display("test ultra done");
   endtask : t_ultra
   task automatic t_cfg(input logic [7:0] last, input logic exp);
      u_host.send({24'h3D2A80, last}, 32);
      chk(rdy === 1'b0 && p256 === ~exp, "no busy at start");
      repeat (100) if (rdy !== 1'b1) @(posedge clk);
      chk(rdy === 1'b1 && p256 === exp, "size not applied");
      $display("test page size done");
   endtask : t_cfg
   task automatic conclude();
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   initial begin
      rst  = 1'b1;
      busy = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      repeat (5) @(posedge clk);
      t_reset();
      t_deep();
      t_ultra();
      t_cfg(8'hA6, 1'b1);
      t_cfg(8'hA7, 1'b0);
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
endmodule : flash_power_mode_and_page_size_control_test

// file: test/fpm_ctrl_chk.sv
// Temporal checks on the ports of the power-mode controller.
// Assumes the host keeps chip select high between frames.
`timescale 1ns/1ps
module fpm_ctrl_chk (
   // Clock and reset.
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   // Inputs.
   input wire logic I_CS_N,
   input wire logic I_ARRAY_BUSY,
   // Status.
   input wire logic O_READY,
   input wire logic O_PAGE_256,
   input wire logic O_DEEP_PD,
   input wire logic O_ULTRA_PD,
   input wire logic O_BUF_UNDEF,
   input wire logic O_CMD_ENABLE
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);
   AST_RST_STANDBY: assert property (disable iff (1'b0) I_RST |->
      O_CMD_ENABLE && !O_DEEP_PD && !O_ULTRA_PD && !O_PAGE_256)
      else $error("reset does not leave standby with 264-byte pages");
   AST_ONE_MODE: assert property (!(O_DEEP_PD && O_ULTRA_PD))
      else $error("both power-down modes at once");
   AST_CMD_GATED: assert property (O_CMD_ENABLE |->
      !O_DEEP_PD && !O_ULTRA_PD) else $error("commands open in power-down");
   AST_BUF_STICKY: assert property (O_BUF_UNDEF |=> O_BUF_UNDEF)
      else $error("buffer-undefined flag dropped");
   AST_BUF_ON_ULTRA: assert property ($rose(O_ULTRA_PD) |->
      ##[0:100] O_BUF_UNDEF) else $error("buffers not marked undefined");
   AST_PAGE_AFTER_BUSY: assert property ($changed(O_PAGE_256) |->
      $past(!O_READY)) else $error("page size changed outside a cycle");
   AST_BUSY_NOT_READY: assert property (I_ARRAY_BUSY |-> !O_READY)
      else $error("ready while the array is busy");
   AST_RESUME_STANDBY: assert property ($fell(O_DEEP_PD) |->
      O_CMD_ENABLE) else $error("resume did not reach standby");
   AST_EXIT_STANDBY: assert property ($fell(O_ULTRA_PD) |->
      O_CMD_ENABLE) else $error("exit did not reach standby");
   AST_DEEP_DESELECTED: assert property ($rose(O_DEEP_PD) |->
      I_CS_N) else $error("deep power-down entered while selected");
   COV_DEEP: cover property ($rose(O_DEEP_PD));
   COV_ULTRA: cover property ($fell(O_ULTRA_PD));
   COV_PAGE: cover property ($rose(O_PAGE_256));
endmodule : fpm_ctrl_chk
bind fpm_ctrl fpm_ctrl_chk u_chk (.I_CLK_SYS, .I_RST, .I_CS_N, .I_ARRAY_BUSY,
   .O_READY, .O_PAGE_256, .O_DEEP_PD, .O_ULTRA_PD, .O_BUF_UNDEF,
   .O_CMD_ENABLE);

// file: test/fpm_host_model.sv
// SPI host that frames commands for the power-mode controller.
// Assumes the bench clock is the 20 MHz system clock of the device.
`timescale 1ns/1ps
module fpm_host_model (
   // Clock.
   input  wire logic i_clk,
   // Pins.
   output logic      o_cs_n,
   output logic      o_sck,
   output logic      o_si
);
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_si   = 1'b0;
   end
   // Shifts n bits of d, first bit at d[31], with SCK low outside frames.
   task automatic send(input logic [31:0] d, input int n);
      int i;
      @(posedge i_clk);
      #1 o_cs_n = 1'b0;
      for (i = 0; i < n; i++) begin
         o_si = d[31-i];
         repeat (4) @(posedge i_clk);
         #1 o_sck = 1'b1;
         repeat (4) @(posedge i_clk);
         #1 o_sck = 1'b0;
      end
      repeat (4) @(posedge i_clk);
      #1 o_cs_n = 1'b1;
      // A released data line must not keep showing the last bit.
      o_si = ~o_si;
      repeat (10) @(posedge i_clk);
   endtask : send
endmodule : fpm_host_model
